// file: core/lftc_counter.sv
// Low-frequency tick counter with an AHB-Lite register slave.
// Assumes mclk runs whenever software touches the registers and the
// low-frequency clock arrives as an asynchronous pin.
//
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps

// Functional notes
// R1 - 24-bit up-counter behind a 12-bit prescaler of low-frequency edges.
// R2 - Counter advances only on low-frequency clock edges.
// R3 - Prescaler zero: one step per low-frequency period, about 30.517 us.
// R4 - Step rate is 32.768 kHz divided by prescaler plus one.
// R5 - Step when internal count is zero, then reload it from prescaler.
// R6 - Prescaler writable only while stopped; writes otherwise ignored.
// R7 - Start, clear and near-wrap tasks reload the internal count.
// R8 - Enabled tick event fires once per counter step.
// R9 - Tick event disabled after reset.
// R10 - Near-wrap task loads the counter with 0xFFFFF0.
// R11 - Wrap event fires when counter rolls from 0xFFFFFF to zero.
// R12 - Wrap event disabled after reset.
// R13 - Per-event enable; disabled events neither fire nor request clocks.
// R14 - Software starts the low-frequency clock before using the counter.
// R15 - Software keeps tick disabled when unneeded to save power.
// R16 - Bus counter read returns a value latched at read time.
// R17 - Start runs, stop halts keeping value, clear zeroes the counter.
// R18 - Crossings into the counter logic use proper synchronisers.
module lftc_counter (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic lowFreqClock,
  input wire lftc_pkg::lftc_ahb_s ahbReq,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  output logic tickEvent,
  output logic wrapEvent,
  output logic periphBusClockReq,
  output logic highFreqClockReq
);
  import lftc_pkg::*;

  // ----------------------------------------------------------------
  // State of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic aValid;
    logic aWrite;
    logic [11:0] aAddr;
    logic [31:0] rdata;
    lftc_task_s pend;
    logic running;
    logic [CNT_W-1:0] counter;
    logic [PRESC_W-1:0] prescaler;
    logic [EV_W-1:0] eventEnableMask;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] intMask;
    logic tickPulse;
    logic wrapPulse;
    logic clkReq;
  } lftc_main_s;

  localparam lftc_main_s MAIN_RESET = '{
    aValid: 1'b0,
    aWrite: 1'b0,
    aAddr: 12'h000,
    rdata: 32'h00000000,
    pend: TASK_NONE,
    running: 1'b0,
    counter: CNT_RESET,
    prescaler: PRESC_RESET,
    eventEnableMask: EV_RESET,
    status: EV_RESET,
    intMask: EV_RESET,
    tickPulse: 1'b0,
    wrapPulse: 1'b0,
    clkReq: 1'b0
  };

  lftc_main_s st;
  lftc_main_s next_st;

  logic lfRise;
  logic presAtZero;
  logic presStep;
  logic presReload;
  logic addrTaken;
  lftc_task_s newTask;
  lftc_reg_e wrSel;
  lftc_reg_e rdSel;
  logic [EV_W-1:0] fired;
  logic [CNT_W-1:0] incCount;
  logic wrData;
  logic prescOpen;
  logic wrStatus;
  logic wrMask;
  logic wrEnable;
  logic wrPresc;
  logic doStop;
  logic doStart;
  logic doClear;
  logic doNearWrap;
  logic doStep;
  logic cntWraps;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Map a byte offset onto a register; shared by read and write
  function automatic lftc_reg_e regSelect(input logic [11:0] ofs);
    lftc_reg_e sel;
    sel = REG_NONE;
    if (ofs == OFS_TASK_START) begin
      sel = REG_START;
    end else if (ofs == OFS_TASK_STOP) begin
      sel = REG_STOP;
    end else if (ofs == OFS_TASK_CLEAR) begin
      sel = REG_CLEAR;
    end else if (ofs == OFS_TASK_NEAR_WRAP) begin
      sel = REG_NEAR_WRAP;
    end else if (ofs == OFS_EVENT_STATUS) begin
      sel = REG_STATUS;
    end else if (ofs == OFS_INT_MASK) begin
      sel = REG_MASK;
    end else if (ofs == OFS_EVENT_ENABLE) begin
      sel = REG_ENABLE;
    end else if (ofs == OFS_COUNTER) begin
      sel = REG_COUNTER;
    end else if (ofs == OFS_PRESCALER) begin
      sel = REG_PRESC;
    end else if (ofs == OFS_RUN_STATUS) begin
      sel = REG_RUN;
    end
    return sel;
  endfunction

  // Zero-extend an event field to a bus word
  function automatic logic [31:0] evWord(input logic [EV_W-1:0] v);
    return {{(32 - EV_W){1'b0}}, v};
  endfunction

  // Bus word of the register picked by a read address
  function automatic logic [31:0] readWord(input lftc_reg_e sel,
    input lftc_main_s s);
    logic [31:0] word;
    word = 32'h00000000;
    if (sel == REG_STATUS) begin
      word = evWord(s.status);
    end else if (sel == REG_MASK) begin
      word = evWord(s.intMask);
    end else if (sel == REG_ENABLE) begin
      word = evWord(s.eventEnableMask);
    end else if (sel == REG_COUNTER) begin
      word = {8'h00, s.counter}; // [R16]
    end else if (sel == REG_PRESC) begin
      word = {20'h00000, s.prescaler};
    end else if (sel == REG_RUN) begin
      word = {31'h00000000, s.running};
    end
    return word;
  endfunction

  // ----------------------------------------------------------------
  // Low-frequency edge detection and the prescale divider
  // ----------------------------------------------------------------
  lftc_sync u_sync (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .lfPin(lowFreqClock),
    .lfRise(lfRise)
  );

  lftc_prescaler u_presc (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .step(presStep),
    .reload(presReload),
    .prescaler(st.prescaler),
    .atZero(presAtZero)
  );

  // Tasks act only on a low-frequency edge
  assign presReload = doClear | doNearWrap | doStart; // [R7]
  assign presStep = lfRise & st.running & ~st.pend.stop &
                    ~presReload; // [R2]

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign addrTaken = ahbReq.hsel & ahbReq.hready &
                     (ahbReq.htrans == HTRANS_NONSEQ);
  assign wrSel = regSelect(st.aAddr);
  assign rdSel = regSelect(ahbReq.haddr[11:0]);
  assign incCount = st.counter + CNT_ONE;

  // ----------------------------------------------------------------
  // Task qualifiers for the low-frequency edge
  // ----------------------------------------------------------------
  // Stop beats start; clear beats near-wrap beats a count step
  assign doStop = lfRise & st.pend.stop;
  assign doStart = lfRise & st.pend.start & ~st.pend.stop;
  assign doClear = lfRise & st.pend.clear;
  assign doNearWrap = lfRise & st.pend.nearWrap & ~st.pend.clear;
  assign doStep = presStep & presAtZero; // [R5]
  assign cntWraps = (st.counter == CNT_MAX); // [R11]

  // ----------------------------------------------------------------
  // Register write strobes in the data phase
  // ----------------------------------------------------------------
  // Prescaler is locked once running or a start is pending
  assign wrData = st.aValid & st.aWrite;
  assign prescOpen = ~st.running & ~st.pend.start; // [R6]

  // One strobe per writable register
  always_comb begin
    wrStatus = 1'b0;
    wrMask = 1'b0;
    wrEnable = 1'b0;
    wrPresc = 1'b0;
    if (wrData) begin
      if (wrSel == REG_STATUS) begin
        wrStatus = 1'b1;
      end else if (wrSel == REG_MASK) begin
        wrMask = 1'b1;
      end else if (wrSel == REG_ENABLE) begin
        wrEnable = 1'b1;
      end else if (wrSel == REG_PRESC) begin
        wrPresc = prescOpen; // [R6]
      end
    end
  end

  // Task strobes written by the bus in the data phase
  always_comb begin
    newTask = TASK_NONE;
    if (st.aValid && st.aWrite && ahbReq.hwdata[TASK_BIT]) begin
      if (wrSel == REG_START) begin
        newTask.start = 1'b1;
      end else if (wrSel == REG_STOP) begin
        newTask.stop = 1'b1;
      end else if (wrSel == REG_CLEAR) begin
        newTask.clear = 1'b1;
      end else if (wrSel == REG_NEAR_WRAP) begin
        newTask.nearWrap = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    fired = EV_RESET;
    next_st.tickPulse = 1'b0;
    next_st.wrapPulse = 1'b0;
    next_st.clkReq = 1'b0;

    // Address phase capture
    next_st.aValid = addrTaken;
    if (addrTaken) begin
      next_st.aWrite = ahbReq.hwrite;
      next_st.aAddr = ahbReq.haddr[11:0];
    end

    // Register writes in the data phase
    if (wrStatus) begin
      next_st.status = st.status & ~ahbReq.hwdata[EV_W-1:0];
    end
    if (wrMask) begin
      next_st.intMask = ahbReq.hwdata[EV_W-1:0];
    end
    if (wrEnable) begin
      next_st.eventEnableMask = ahbReq.hwdata[EV_W-1:0]; // [R13]
    end
    if (wrPresc) begin
      next_st.prescaler = ahbReq.hwdata[PRESC_W-1:0]; // [R6]
    end

    // Task execution on a low-frequency edge
    if (doStop) begin
      next_st.running = 1'b0; // [R17]
    end else if (doStart) begin
      next_st.running = 1'b1; // [R17]
    end
    if (doClear) begin
      next_st.counter = CNT_RESET; // [R17]
    end else if (doNearWrap) begin
      next_st.counter = CNT_NEAR_WRAP; // [R10]
    end else if (doStep) begin
      next_st.counter = incCount; // [R1] [R3] [R5]
      fired[EV_TICK] = st.eventEnableMask[EV_TICK]; // [R8] [R13]
      if (cntWraps) begin
        fired[EV_WRAP] = st.eventEnableMask[EV_WRAP]; // [R11]
      end
    end

    // Pending tasks: consumed on an edge, new writes always kept
    next_st.pend = (lfRise ? TASK_NONE : st.pend) | newTask; // [R18]

    // Sticky status: a new event wins over a clear
    next_st.status = next_st.status | fired;
    next_st.tickPulse = fired[EV_TICK];
    next_st.wrapPulse = fired[EV_WRAP];
    next_st.clkReq = |fired; // [R13]

    // Read data from post-write values, so a read right after a write sees it
    if (addrTaken && !ahbReq.hwrite) begin
      next_st.rdata = readWord(rdSel, next_st); // [R16]
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= MAIN_RESET; // [R9] [R12]
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Bus answer: zero wait states, stalled while frozen
  assign hreadyout = ce;
  assign hresp = HRESP_OKAY;
  assign hrdata = st.rdata;

  // Events and interrupt
  assign irq = |(st.status & st.intMask);
  assign tickEvent = st.tickPulse;
  assign wrapEvent = st.wrapPulse;

  // Clock requests only for enabled events
  assign periphBusClockReq = st.clkReq; // [R13]
  assign highFreqClockReq = st.clkReq; // [R13]

endmodule

// file: inc/lftc_pkg.sv
// Package for the low-frequency tick counter: offsets, fields, types.
// Assumes a single bus clock mclk; the low-frequency clock is a pin.
package lftc_pkg;

  // ----------------------------------------------------------------
  // Widths and counter values
  // ----------------------------------------------------------------
  localparam int CNT_W = 24;
  localparam int PRESC_W = 12;
  localparam int EV_W = 2;
  localparam logic [CNT_W-1:0] CNT_RESET = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_NEAR_WRAP = 24'hFFFFF0;
  localparam logic [CNT_W-1:0] CNT_MAX = 24'hFFFFFF;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
  localparam logic [PRESC_W-1:0] PRESC_RESET = 12'h000;
  localparam logic [PRESC_W-1:0] PRESC_ONE = 12'h001;
  localparam logic [EV_W-1:0] EV_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int LF_FREQ_HZ = 32768;
  localparam int LF_PERIOD_NS = 30517;
  localparam int MCLK_PERIOD_NS = 10;
  localparam int LF_PERIOD_CYC = LF_PERIOD_NS / MCLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses) and field positions
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_TASK_START = 12'h000;
  localparam logic [11:0] OFS_TASK_STOP = 12'h004;
  localparam logic [11:0] OFS_TASK_CLEAR = 12'h008;
  localparam logic [11:0] OFS_TASK_NEAR_WRAP = 12'h00C;
  localparam logic [11:0] OFS_EVENT_STATUS = 12'h100;
  localparam logic [11:0] OFS_INT_MASK = 12'h104;
  localparam logic [11:0] OFS_EVENT_ENABLE = 12'h108;
  localparam logic [11:0] OFS_COUNTER = 12'h10C;
  localparam logic [11:0] OFS_PRESCALER = 12'h110;
  localparam logic [11:0] OFS_RUN_STATUS = 12'h114;
  localparam int TASK_BIT = 0;
  localparam int EV_TICK = 0;
  localparam int EV_WRAP = 1;

  // ----------------------------------------------------------------
  // Bus encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

  typedef enum {
    REG_NONE, REG_START, REG_STOP, REG_CLEAR, REG_NEAR_WRAP,
    REG_STATUS, REG_MASK, REG_ENABLE, REG_COUNTER, REG_PRESC, REG_RUN
  } lftc_reg_e;

  // AHB-Lite request from the master side
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } lftc_ahb_s;

  // Pending tasks, executed on a low-frequency edge
  typedef struct packed {
    logic start;
    logic stop;
    logic clear;
    logic nearWrap;
  } lftc_task_s;

  localparam lftc_task_s TASK_NONE = '{default: 1'b0};

endpackage

// file: core/lftc_sync.sv
// Synchroniser and rising-edge finder for the low-frequency clock pin.
// Assumes the pin is asynchronous to mclk and much slower than it.
`timescale 1ns/10ps

module lftc_sync (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic lfPin,
  output logic lfRise
);
  import lftc_pkg::*;

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } lftc_sync_s;

  lftc_sync_s st;
  lftc_sync_s next_st;

  // ----------------------------------------------------------------
  // Two-stage capture, then a delayed copy for edge finding
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.meta = lfPin;
    next_st.sync = st.meta; // [R18]
    next_st.last = st.sync;
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= '{default: 1'b0};
    end else if (ce) begin
      st <= next_st;
    end
  end

  // One-cycle pulse per low-frequency rising edge
  assign lfRise = st.sync & ~st.last; // [R2]

endmodule

// file: core/lftc_prescaler.sv
// Internal prescale count that divides low-frequency edges.
// Assumes step and reload come from logic on mclk.
`timescale 1ns/10ps

module lftc_prescaler (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic step,
  input wire logic reload,
  input wire logic [lftc_pkg::PRESC_W-1:0] prescaler,
  output logic atZero
);
  import lftc_pkg::*;

  typedef struct packed {
    logic [PRESC_W-1:0] count;
  } lftc_presc_s;

  lftc_presc_s st;
  lftc_presc_s next_st;

  // ----------------------------------------------------------------
  // Reload on tasks, count down per edge, reload after zero
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (reload) begin
      next_st.count = prescaler; // [R7]
    end else if (step) begin
      if (st.count == PRESC_RESET) begin
        next_st.count = prescaler; // [R5]
      end else begin
        next_st.count = st.count - PRESC_ONE; // [R4]
      end
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= '{count: PRESC_RESET};
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign atZero = (st.count == PRESC_RESET); // [R5]

endmodule

// file: bench/lftc_counter_properties.sv
// Checker for the tick counter: port relations over time.
// Assumes it is bound onto lftc_counter with one clock, mclk.
`timescale 1ns/10ps
module lftc_check (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic lowFreqClock,
  input wire lftc_pkg::lftc_ahb_s ahbReq,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic irq,
  input wire logic tickEvent,
  input wire logic wrapEvent,
  input wire logic periphBusClockReq,
  input wire logic highFreqClockReq
);
  import lftc_pkg::*;
  logic lfPrev;
  logic [7:0] sinceRise;
  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  // Cycles since the last rising edge of the pin
  always_ff @(posedge mclk) begin
    lfPrev <= lowFreqClock;
    if (rst) begin
      sinceRise <= 8'hFF;
    end else if (lowFreqClock && !lfPrev) begin
      sinceRise <= 8'h00;
    end else if (sinceRise != 8'hFF) begin
      sinceRise <= sinceRise + 8'h01;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_tick_near_lf: assert property (tickEvent |-> sinceRise < 8'h08)
    else $error("tick not near a low-frequency edge");
  a_wrap_near_lf: assert property (wrapEvent |-> sinceRise < 8'h08)
    else $error("wrap not near a low-frequency edge");
  a_tick_single: assert property (tickEvent |=> !tickEvent [*8])
    else $error("tick pulse repeated");
  a_tick_clk_req: assert property (tickEvent |-> periphBusClockReq)
    else $error("tick without clock request");
  a_req_has_cause: assert property
    (periphBusClockReq |-> tickEvent || wrapEvent)
    else $error("clock request without event");
  a_req_pair: assert property
    (periphBusClockReq == highFreqClockReq)
    else $error("clock requests differ");
  a_ready_ce: assert property (hreadyout == ce)
    else $error("ready differs from enable");
  a_resp_okay: assert property (hresp == HRESP_OKAY)
    else $error("response not okay");
  a_reset_quiet: assert property (disable iff (1'b0)
    rst |=> !irq && !tickEvent && !wrapEvent)
    else $error("activity during reset");
  c_tick: cover property (tickEvent);
  c_wrap: cover property (wrapEvent);
  c_irq: cover property (irq);
endmodule

bind lftc_counter lftc_check i_check (.mclk(mclk), .rst(rst), .ce(ce),
  .lowFreqClock(lowFreqClock), .ahbReq(ahbReq), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .irq(irq), .tickEvent(tickEvent),
  .wrapEvent(wrapEvent), .periphBusClockReq(periphBusClockReq),
  .highFreqClockReq(highFreqClockReq));

// file: bench/lftc_counter_bench.sv
// Self-checking bench for the low-frequency tick counter.
// Assumes the checker is bound separately; mclk at 100 MHz.
`timescale 1ns/10ps
module lftc_counter_bench;
  import lftc_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic lowFreqClock = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  lftc_ahb_s ahbReq;
  logic hreadyout, hresp, irq, tickEvent, wrapEvent, pReq, hReq;
  logic [31:0] hrdata, rd, c1;
  logic lfOn = 1'b0;
  logic ceOn = 1'b1;
  logic [4:0] lfDiv = 5'h00;
  int nRise = 0;
  int n_errors = 0;
  int n_checks = 0;
  assign ahbReq = '{hsel: 1'b1, haddr: haddr, htrans: htrans,
    hwrite: hwrite, hsize: 3'h2, hready: hreadyout, hwdata: hwdata};
  // Clock
  always #5 mclk = ~mclk;
  // Pin clock, 40 mclk period, counting rising edges
  always @(posedge mclk) begin
    if (lfOn) begin
      lfDiv <= lfDiv + 5'h01;
      if (lfDiv == 5'h13) begin
        lfDiv <= 5'h00;
        lowFreqClock <= ~lowFreqClock;
        if (!lowFreqClock) nRise <= nRise + 1;
      end
    end
  end
  lftc_counter i_dut (.mclk(mclk), .rst(rst), .ce(ceOn),
    .lowFreqClock(lowFreqClock), .ahbReq(ahbReq), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .irq(irq), .tickEvent(tickEvent),
    .wrapEvent(wrapEvent), .periphBusClockReq(pReq),
    .highFreqClockReq(hReq));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task complete_run();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task check(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task waitReady();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (hreadyout !== 1'b1) begin
      n_errors++;
      complete_run();
    end
  endtask
  task bus(input logic [11:0] a, input logic w, input logic [31:0] wd);
    @(posedge mclk);
    haddr <= {20'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    waitReady();
    htrans <= 2'h0;
    hwdata <= wd;
    waitReady();
    rd = hrdata;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] e, input string s);
    bus(a, 1'b0, 32'h0);
    check(s, e, rd);
  endtask
  task waitEvt(input int k, input int lim, output logic seen);
    seen = 1'b0;
    for (int i = 0; i < lim && !seen; i++) begin
      @(negedge mclk);
      seen = (k == 0) ? (tickEvent === 1'b1) : (wrapEvent === 1'b1);
    end
  endtask
  task needEvt(input int k);
    logic s;
    waitEvt(k, 3000, s);
    check("event seen", 1, s);
    if (!s) complete_run();
  endtask
  task waitRises(input int n);
    int r;
    r = nRise + n;
    for (int i = 0; i < 2000 && nRise < r; i++) @(negedge mclk);
    if (nRise < r) begin
      n_errors++;
      complete_run();
    end
  endtask
  task spacing(input int p);
    int r;
    needEvt(0);
    r = nRise;
    needEvt(0);
    check("rises per tick", p + 1, nRise - r);
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic s;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rdchk(OFS_EVENT_ENABLE, 32'h0, "enables");
    rdchk(OFS_COUNTER, 32'h0, "counter");
    rdchk(12'h200, 32'h0, "unmapped");
    wr(OFS_PRESCALER, 32'hFFFFFFFF);
    rdchk(OFS_PRESCALER, 32'hFFF, "prescaler");
    wr(OFS_PRESCALER, 32'h1);
    wr(OFS_EVENT_ENABLE, 32'h1);
    wr(OFS_INT_MASK, 32'h1);
    lfOn <= 1'b1;
    wr(OFS_TASK_START, 32'h1);
    waitRises(3);
    rdchk(OFS_RUN_STATUS, 32'h1, "running");
    wr(OFS_PRESCALER, 32'h5);
    rdchk(OFS_PRESCALER, 32'h1, "prescaler locked");
    spacing(1);
    bus(OFS_COUNTER, 1'b0, 32'h0);
    c1 = rd;
    needEvt(0);
    rdchk(OFS_COUNTER, c1 + 1, "counter step");
    check("irq on tick", 1, irq);
    wr(OFS_EVENT_ENABLE, 32'h0);
    wr(OFS_EVENT_STATUS, 32'h3);
    @(negedge mclk);
    check("irq cleared", 0, irq);
    waitEvt(0, 400, s);
    check("tick while disabled", 0, s);
    wr(OFS_TASK_STOP, 32'h1);
    waitRises(3);
    bus(OFS_COUNTER, 1'b0, 32'h0);
    c1 = rd;
    waitRises(3);
    rdchk(OFS_COUNTER, c1, "stopped");
    rdchk(OFS_RUN_STATUS, 32'h0, "halted");
    wr(OFS_TASK_CLEAR, 32'h1);
    ceOn <= 1'b0;
    repeat (200) @(posedge mclk);
    check("ready frozen", 0, hreadyout);
    ceOn <= 1'b1;
    waitRises(3);
    rdchk(OFS_COUNTER, 32'h0, "cleared");
    wr(OFS_PRESCALER, 32'h0);
    wr(OFS_TASK_NEAR_WRAP, 32'h1);
    waitRises(3);
    rdchk(OFS_COUNTER, 32'hFFFFF0, "near wrap");
    wr(OFS_EVENT_ENABLE, 32'h3);
    wr(OFS_INT_MASK, 32'h2);
    wr(OFS_TASK_START, 32'h1);
    spacing(0);
    needEvt(1);
    rdchk(OFS_COUNTER, 32'h0, "after wrap");
    check("irq on wrap", 1, irq);
    wr(OFS_EVENT_STATUS, 32'h2);
    bus(OFS_EVENT_STATUS, 1'b0, 32'h0);
    check("wrap cleared", 0, rd[1]);
    check("irq off", 0, irq);
    complete_run();
  end
endmodule
